// *** low_power_reset_wakeup_ctrl.sv ***
// Power-mode sequencing, reset gathering and wake-up event detection
// Notes on behaviour
// - Sleep stops only processor clock
// - Any interrupt or event ends sleep
// - Stop gates fast clocks, holds state, I/O
// - Deep wake selects fast internal oscillator
// - Standby is stop plus regulator low power
// - Standby exits on reset pin, event lines
// - Supply below threshold forces system reset
// - Over-temperature forces system reset
// - Over-voltage pin resets, stays readable
// - Regulator on after reset, low only standby
// - Auto-wake runs from slow oscillator
// - Bus clock source, 18x multiplier, prescaler
// - Twenty edge lines, edge select, mask, pending
// - Short pulses must still be caught
// - 36 pins routed to 16 lines
`timescale 1ns/10ps
`default_nettype none
module low_power_reset_wakeup_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Processor side
  input  wire logic        wait_instr,
  input  wire logic        irq_in,
  // Wake and reset sources
  input  wire logic [35:0] gpio_in,
  input  wire logic        usb_wake,
  input  wire logic        pd_wake,
  input  wire logic        aux_wake,
  input  wire logic        slow_internal_osc_tick,
  input  wire logic        ext_reset_pin_b,
  input  wire logic        supply_above_threshold,
  input  wire logic        over_temp,
  input  wire logic        over_voltage_guard,
  // Power and clock controls
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             fast_internal_osc_en,
  output logic             external_fast_osc_en,
  output logic             multiplier_en,
  output logic [1:0]       system_bus_clock_sel,
  output logic [3:0]       bus_prescale,
  output logic [4:0]       mult_factor,
  output logic             io_hold,
  output logic             core_reg_on,
  output logic             reg_low_power,
  output logic             sys_reset_b,
  output logic [19:0]      wake_event
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  localparam int L = power_ctrl_pkg::LINES;
  logic [power_ctrl_pkg::CTRL_W-1:0] ctrl;     // Control word
  logic [L-1:0]                 rise_en;       // Rising edge enables
  logic [L-1:0]                 fall_en;       // Falling edge enables
  logic [L-1:0]                 mask;          // 1 lets a line through
  logic [L-1:0]                 pending;       // Sticky requests
  logic [power_ctrl_pkg::AWU_W-1:0] awu_period; // Auto-wake period
  logic [power_ctrl_pkg::AWU_W-1:0] awu_count;  // Auto-wake counter
  logic [31:0]                  route;         // Pin group per line
  logic [3:0]                   rst_flag;      // Reset cause flags
  logic [L-1:0]                 line;          // Line levels
  logic [L-1:0]                 line_prev;     // Previous line levels
  logic [L-1:0]                 edge_set;      // Detected edges
  logic                         awu_evt;       // Auto-wake pulse
  logic [3:0]                   rst_cause;     // Live reset causes
  logic                         deep_wake;     // Wake from stop/standby
  power_ctrl_pkg::power_state_t state;
  power_ctrl_pkg::power_state_t next_state;

  // APB strobes
  logic wr;
  logic setup;
  assign wr    = psel && penable && pwrite;
  assign setup = psel && !penable;

  // ****************************************************************
  // Event lines and edge detection
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < L; g++) begin : g_line
      if (g < power_ctrl_pkg::PIN_LINES) begin : g_pin
        // Pin g, g+16 or g+32; the third group has only four pins
        always_comb begin
          case (route[2*g +: 2])
            2'h1:    line[g] = gpio_in[g+16];
            2'h2:    line[g] = (g + 32 < power_ctrl_pkg::PINS) ?
                               gpio_in[(g+32) % power_ctrl_pkg::PINS] :
                               1'b0;
            default: line[g] = gpio_in[g];
          endcase
        end
      end
      // Edge seen against the previous sample, so a pulse one clock
      // wide is caught; narrower pulses need the pad latch upstream
      assign edge_set[g] = mask[g] &&
        ((rise_en[g] && line[g] && !line_prev[g]) ||
         (fall_en[g] && !line[g] && line_prev[g]));
    end
  endgenerate
  assign line[power_ctrl_pkg::LINE_AWU] = awu_evt;
  assign line[power_ctrl_pkg::LINE_USB] = usb_wake;
  assign line[power_ctrl_pkg::LINE_PD]  = pd_wake;
  assign line[power_ctrl_pkg::LINE_AUX] = aux_wake;

  // Line history for the detectors
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_prev <= '0;
    end else begin
      line_prev <= line;
    end
  end

  // Pending flags: a new edge wins over a software clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pending <= '0;
    end else if (wr && paddr == power_ctrl_pkg::ADDR_PENDING) begin
      pending <= (pending & ~pwdata[L-1:0]) | edge_set;
    end else begin
      pending <= pending | edge_set;
    end
  end
  assign wake_event = edge_set;

  // ****************************************************************
  // Auto-wake unit
  // ****************************************************************
  // Counts slow oscillator ticks, so it runs while fast clocks are off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awu_count <= '0;
      awu_evt   <= 1'b0;
    end else begin
      awu_evt <= 1'b0;
      if (!ctrl[power_ctrl_pkg::CTRL_AWU_EN]) begin
        awu_count <= '0;
      end else if (slow_internal_osc_tick) begin
        if (awu_count == awu_period) begin
          awu_count <= '0;
          awu_evt   <= 1'b1;
        end else begin
          awu_count <= awu_count + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  // Deep modes only listen to event lines; sleep also to interrupts
  assign deep_wake = |(pending | edge_set);

  always_comb begin
    next_state = state;
    case (state)
      power_ctrl_pkg::ST_RUN: begin
        // The core sets the select bits before waiting
        if (wait_instr) begin
          if (!ctrl[power_ctrl_pkg::CTRL_DEEP_SLEEP]) begin
            next_state = power_ctrl_pkg::ST_SLEEP;
          end else if (ctrl[power_ctrl_pkg::CTRL_POWER_DOWN_DEEP_SELECT]) begin
            next_state = power_ctrl_pkg::ST_STANDBY;
          end else begin
            next_state = power_ctrl_pkg::ST_STOP;
          end
        end
      end
      power_ctrl_pkg::ST_SLEEP: begin
        if (irq_in || deep_wake) begin
          next_state = power_ctrl_pkg::ST_RUN;
        end
      end
      power_ctrl_pkg::ST_STOP,
      power_ctrl_pkg::ST_STANDBY: begin
        if (deep_wake) begin
          next_state = power_ctrl_pkg::ST_RUN;
        end
      end
      default: next_state = power_ctrl_pkg::ST_RUN;
    endcase
  end

  // State register; the reset pin exit comes through rst_b
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= power_ctrl_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Clock, regulator and hold outputs
  // ****************************************************************
  always_comb begin
    cpu_clk_en    = (state == power_ctrl_pkg::ST_RUN);
    periph_clk_en = (state == power_ctrl_pkg::ST_RUN) ||
                    (state == power_ctrl_pkg::ST_SLEEP);
    io_hold       = (state == power_ctrl_pkg::ST_STOP) ||
                    (state == power_ctrl_pkg::ST_STANDBY);
    reg_low_power = (state == power_ctrl_pkg::ST_STANDBY);
    // Whole fast domain goes down in both deep modes
    fast_internal_osc_en = !io_hold;
    external_fast_osc_en = !io_hold && system_bus_clock_sel ==
                           power_ctrl_pkg::CLK_EXT_FAST;
    multiplier_en        = !io_hold && system_bus_clock_sel ==
                           power_ctrl_pkg::CLK_MULT;
  end
  assign system_bus_clock_sel =
    ctrl[power_ctrl_pkg::CTRL_CLK_LO +: 2];
  assign bus_prescale = ctrl[power_ctrl_pkg::CTRL_PRE_LO +: 4];
  assign mult_factor  = power_ctrl_pkg::MULT_FACTOR;

  // Regulator comes up on after every reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_reg_on <= 1'b0;
    end else begin
      core_reg_on <= 1'b1;
    end
  end

  // ****************************************************************
  // Reset gathering
  // ****************************************************************
  assign rst_cause = {!ext_reset_pin_b, over_voltage_guard, over_temp,
                      !supply_above_threshold};

  // System reset is held while any cause stands and while rst_b is low;
  // after rst_b rises, a cause at power-up is seen from the first edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_b <= 1'b0;
    end else begin
      sys_reset_b <= !(|rst_cause);
    end
  end

  // Sticky cause flags, write one to clear, set wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_flag <= '0;
    end else if (wr && paddr == power_ctrl_pkg::ADDR_STATUS) begin
      rst_flag <= (rst_flag &
                   ~pwdata[power_ctrl_pkg::ST_FLAG_LO +: 4]) | rst_cause;
    end else begin
      rst_flag <= rst_flag | rst_cause;
    end
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  // Writes land at the access edge; clock select falls back on a wake from stop or standby
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl       <= power_ctrl_pkg::CTRL_RST;
      rise_en    <= '0;
      fall_en    <= '0;
      mask       <= '0;
      awu_period <= power_ctrl_pkg::AWU_RST;
      route      <= '0;
    end else begin
      if (wr) begin
        case (paddr)
          power_ctrl_pkg::ADDR_CTRL:  ctrl <= pwdata[8:0];
          power_ctrl_pkg::ADDR_RISE:  rise_en <= pwdata[L-1:0];
          power_ctrl_pkg::ADDR_FALL:  fall_en <= pwdata[L-1:0];
          power_ctrl_pkg::ADDR_MASK:  mask <= pwdata[L-1:0];
          power_ctrl_pkg::ADDR_AWU:   awu_period <= pwdata[15:0];
          power_ctrl_pkg::ADDR_ROUTE: route <= pwdata;
          default: ;
        endcase
      end
      if (io_hold && next_state == power_ctrl_pkg::ST_RUN) begin
        ctrl[power_ctrl_pkg::CTRL_CLK_LO +: 2] <=
          power_ctrl_pkg::CLK_FAST_INT;
      end
    end
  end

  // Read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= paddr > power_ctrl_pkg::ADDR_ROUTE || paddr[1:0] != 2'h0;
      case (paddr)
        power_ctrl_pkg::ADDR_CTRL:    prdata <= {23'h0, ctrl};
        power_ctrl_pkg::ADDR_STATUS:  prdata <= {23'h0,
                                          over_voltage_guard,
                                          rst_flag, state};
        power_ctrl_pkg::ADDR_RISE:    prdata <= {12'h0, rise_en};
        power_ctrl_pkg::ADDR_FALL:    prdata <= {12'h0, fall_en};
        power_ctrl_pkg::ADDR_MASK:    prdata <= {12'h0, mask};
        power_ctrl_pkg::ADDR_PENDING: prdata <= {12'h0, pending};
        power_ctrl_pkg::ADDR_AWU:     prdata <= {16'h0, awu_period};
        power_ctrl_pkg::ADDR_ROUTE:   prdata <= route;
        default:                      prdata <= '0;
      endcase
    end
  end
  assign pready = 1'b1;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // One clock domain, so clock and reset are given once for all checks
  default clocking assert_clk @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_deep;
    state == power_ctrl_pkg::ST_STOP || state == power_ctrl_pkg::ST_STANDBY;
  endsequence
  sequence s_back_run;
    state == power_ctrl_pkg::ST_RUN;
  endsequence

  a_sleep_cpu_gate: assert property (
    state == power_ctrl_pkg::ST_SLEEP |-> !cpu_clk_en && periph_clk_en)
    else $error("sleep clock gating wrong");
  a_sleep_irq_exit: assert property (
    state == power_ctrl_pkg::ST_SLEEP && irq_in |=> s_back_run)
    else $error("sleep not left on interrupt");
  a_deep_fast_off: assert property (
    s_deep |-> !fast_internal_osc_en && !multiplier_en && io_hold)
    else $error("fast domain alive in deep mode");
  // Clock select is forced at the wake edge itself, so no slack here
  a_wake_fast_osc: assert property (
    s_deep ##1 s_back_run |->
      system_bus_clock_sel == power_ctrl_pkg::CLK_FAST_INT)
    else $error("wake without fast internal osc");
  a_standby_reg_lp: assert property (
    reg_low_power == (state == power_ctrl_pkg::ST_STANDBY))
    else $error("regulator mode wrong");
  a_deep_event_exit: assert property (
    s_deep and (|edge_set) |=> s_back_run)
    else $error("deep mode not left on event");
  a_reset_cause: assert property (
    (|rst_cause) |=> !sys_reset_b)
    else $error("reset cause not forced");
  a_reset_release: assert property (
    !(|rst_cause) |=> sys_reset_b)
    else $error("system reset held without cause");
  a_pending_set: assert property (
    (|edge_set) |=> (pending & $past(edge_set)) == $past(edge_set))
    else $error("edge lost from pending");
  a_awu_slow_tick: assert property (
    $rose(awu_evt) |-> $past(slow_internal_osc_tick))
    else $error("auto-wake without slow tick");

endmodule
`default_nettype wire

// *** power_ctrl_pkg.sv ***
// Constants, register map and state encodings of the low-power controller
package power_ctrl_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // Mode and clock control
  localparam logic [7:0] ADDR_STATUS  = 8'h04; // State and reset causes
  localparam logic [7:0] ADDR_RISE    = 8'h08; // Rising edge enables
  localparam logic [7:0] ADDR_FALL    = 8'h0c; // Falling edge enables
  localparam logic [7:0] ADDR_MASK    = 8'h10; // Line unmask bits
  localparam logic [7:0] ADDR_PENDING = 8'h14; // Pending flags, W1C
  localparam logic [7:0] ADDR_AWU     = 8'h18; // Auto-wake period
  localparam logic [7:0] ADDR_ROUTE   = 8'h1c; // Pin routing, 2b/line

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_DEEP_SLEEP = 0;  // Deep sleep select
  localparam int CTRL_POWER_DOWN_DEEP_SELECT       = 1;  // Power down deep select
  localparam int CTRL_CLK_LO     = 2;  // Clock source select [3:2]
  localparam int CTRL_PRE_LO     = 4;  // Bus prescaler [7:4]
  localparam int CTRL_AWU_EN     = 8;  // Auto-wake enable
  localparam int CTRL_W          = 9;
  localparam int ST_FLAG_LO      = 4;  // Reset cause flags [7:4]
  localparam int ST_OV_LEVEL     = 8;  // Live over-voltage compare

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int LINES     = 20;       // Edge detector count
  localparam int PIN_LINES = 16;       // Lines fed from I/O pins
  localparam int PINS      = 36;       // General I/O pins
  localparam int AWU_W     = 16;       // Auto-wake counter width
  localparam int LINE_AWU  = 16;       // Auto-wake line
  localparam int LINE_USB  = 17;       // USB wake line
  localparam int LINE_PD   = 18;       // Power-delivery wake line
  localparam int LINE_AUX  = 19;       // Spare wake line
  localparam logic [4:0] MULT_FACTOR = 5'h12; // Multiplier, 18x
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [AWU_W-1:0]  AWU_RST  = 16'hffff;

  // Clock source codes
  localparam logic [1:0] CLK_FAST_INT = 2'h0; // Fast internal osc
  localparam logic [1:0] CLK_EXT_FAST = 2'h1; // External fast osc
  localparam logic [1:0] CLK_MULT     = 2'h2; // Through multiplier

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_SLEEP   = 4'h2,
    ST_STOP    = 4'h4,
    ST_STANDBY = 4'h8
  } power_state_t;

endpackage

// *** wake_source_model.sv ***
// Behavioural model of the processor core and the wake and reset sources
`timescale 1ns/10ps
`default_nettype none
module wake_source_model (
  input  wire logic   clock,
  input  wire logic   rst_b,
  output logic        wait_instr,
  output logic        irq_in,
  output logic [35:0] gpio_in,
  output logic        usb_wake,
  output logic        pd_wake,
  output logic        aux_wake,
  output logic        slow_internal_osc_tick,
  output logic        ext_reset_pin_b,
  output logic        supply_above_threshold,
  output logic        over_temp,
  output logic        over_voltage_guard
);
  // ****************************************************************
  // Source levels
  // ****************************************************************
  logic [2:0] slow_div; // Stands in for the slow oscillator period

  // Quiet sources at time zero, supply good, no faults
  initial begin
    wait_instr = 1'b0;
    irq_in = 1'b0;
    gpio_in = 36'h0;
    usb_wake = 1'b0;
    pd_wake = 1'b0;
    aux_wake = 1'b0;
    slow_internal_osc_tick = 1'b0;
    ext_reset_pin_b = 1'b1;
    supply_above_threshold = 1'b1;
    over_temp = 1'b0;
    over_voltage_guard = 1'b0;
    slow_div = 3'h0;
  end

  // Slow oscillator ticks free, ignoring reset, as a real RC would
  always @(posedge clock) begin
    slow_div <= slow_div + 3'h1;
    slow_internal_osc_tick <= (slow_div == 3'h7);
  end

  // ****************************************************************
  // Core and fault tasks
  // ****************************************************************
  // Mode bits are written by software first, then one wait pulse
  task automatic issue_wait();
    wait_instr <= 1'b1;
    @(posedge clock);
    wait_instr <= 1'b0;
  endtask

  // Raise or drop one reset cause: 0 supply, 1 heat, 2 volts, 3 pin
  task automatic set_cause(input int idx, input logic on);
    case (idx)
      0: supply_above_threshold <= ~on;
      1: over_temp <= on;
      2: over_voltage_guard <= on;
      default: ext_reset_pin_b <= ~on;
    endcase
  endtask
endmodule
`default_nettype wire

// *** low_power_reset_wakeup_ctrl_bench.sv ***
// Self-checking bench of the low-power reset and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module low_power_reset_wakeup_ctrl_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clock, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, seen;
  logic        wait_instr, irq_in, usb_wake, pd_wake, aux_wake, tick;
  logic [35:0] gpio_in;
  logic        pin_b, supply_ok, over_temp, ovg;
  logic        cpu_clk_en, periph_clk_en, fast_en, ext_en, mult_en;
  logic [1:0]  system_bus_clock_sel;
  logic [3:0]  bus_prescale;
  logic [4:0]  mult_factor;
  logic        io_hold, core_reg_on, reg_low_power, sys_reset_b;
  logic [19:0] wake_event;
  int          n_fail, tests_run, cycles;
  wire  [5:0]  pwr = {cpu_clk_en, fast_en, ext_en, mult_en, io_hold,
                      reg_low_power}; // Power outputs in one view

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

  wake_source_model P (.clock(clock), .rst_b(rst_b),
    .wait_instr(wait_instr), .irq_in(irq_in), .gpio_in(gpio_in),
    .usb_wake(usb_wake), .pd_wake(pd_wake), .aux_wake(aux_wake),
    .slow_internal_osc_tick(tick), .ext_reset_pin_b(pin_b),
    .supply_above_threshold(supply_ok), .over_temp(over_temp),
    .over_voltage_guard(ovg));

  low_power_reset_wakeup_ctrl DUT (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .wait_instr(wait_instr), .irq_in(irq_in), .gpio_in(gpio_in),
    .usb_wake(usb_wake), .pd_wake(pd_wake), .aux_wake(aux_wake),
    .slow_internal_osc_tick(tick), .ext_reset_pin_b(pin_b),
    .supply_above_threshold(supply_ok), .over_temp(over_temp),
    .over_voltage_guard(ovg), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .fast_internal_osc_en(fast_en),
    .external_fast_osc_en(ext_en), .multiplier_en(mult_en),
    .system_bus_clock_sel(system_bus_clock_sel),
    .bus_prescale(bus_prescale), .mult_factor(mult_factor),
    .io_hold(io_hold), .core_reg_on(core_reg_on),
    .reg_low_power(reg_low_power), .sys_reset_b(sys_reset_b),
    .wake_event(wake_event));

  // ****************************************************************
  // Clock, timeout and verdict
  // ****************************************************************
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // A hung wait must not run forever; all scenarios need far fewer
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // Bus and wait helpers
  // ****************************************************************
  // One APB transfer, entered just after a rising edge; leaves one idle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask

  // Scan a fixed window for one wake pulse; pulses last a single cycle
  task automatic wait_evt(input int b, input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(negedge clock);
      if (wake_event[b] === 1'b1) seen = 1'b1;
    end
    @(posedge clock);
  endtask

  // Enter a deep mode and check the gated outputs at mid-cycle
  task automatic enter(input logic [31:0] ctrl, input logic [5:0] ex);
    apb(1'b1, power_ctrl_pkg::ADDR_CTRL, ctrl);
    P.issue_wait();
    @(negedge clock);
    `CHK("deep_pwr", ex, pwr)
    `CHK("reg_on", 1'b1, core_reg_on)
    @(posedge clock);
  endtask

  // After a deep wake the fast internal source must be back in charge
  task automatic check_woken(input int line);
    @(negedge clock);
    `CHK("woken", 6'h30, {cpu_clk_en, fast_en, io_hold, reg_low_power,
                         system_bus_clock_sel})
    @(posedge clock);
    rdchk("pend", power_ctrl_pkg::ADDR_PENDING, 32'h1 << line);
    apb(1'b1, power_ctrl_pkg::ADDR_PENDING, 32'h1 << line);
    rdchk("pend_clr", power_ctrl_pkg::ADDR_PENDING, 32'h0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sleep();
    // Multiplier source and prescale 5; sleep keeps the fast domain up
    apb(1'b1, power_ctrl_pkg::ADDR_CTRL, 32'h58);
    P.issue_wait();
    @(negedge clock);
    `CHK("sleep", 3'h2, {cpu_clk_en, periph_clk_en, io_hold})
    `CHK("mult_pre", 5'h15, {mult_en, bus_prescale})
    @(posedge clock);
    P.irq_in <= 1'b1;
    repeat (3) @(posedge clock);
    P.irq_in <= 1'b0;
    @(negedge clock);
    `CHK("sleep_exit", 1'b1, cpu_clk_en)
    @(posedge clock);
  endtask

  task automatic t_stop();
    apb(1'b1, power_ctrl_pkg::ADDR_RISE, 32'h8);
    apb(1'b1, power_ctrl_pkg::ADDR_MASK, 32'h8);
    enter(32'h5, 6'h02);
    `CHK("sel_ext", 2'h1, system_bus_clock_sel)
    P.gpio_in[3] <= 1'b1;
    wait_evt(3, 6);
    `CHK("stop_evt", 1'b1, seen)
    check_woken(3);
  endtask

  task automatic t_standby();
    apb(1'b1, power_ctrl_pkg::ADDR_RISE, 32'h0);
    apb(1'b1, power_ctrl_pkg::ADDR_FALL, 32'h20000);
    apb(1'b1, power_ctrl_pkg::ADDR_MASK, 32'h20000);
    P.usb_wake <= 1'b1;
    enter(32'h3, 6'h03);
    P.usb_wake <= 1'b0;
    wait_evt(17, 6);
    `CHK("stby_evt", 1'b1, seen)
    check_woken(17);
  endtask

  task automatic t_autowake();
    apb(1'b1, power_ctrl_pkg::ADDR_FALL, 32'h0);
    apb(1'b1, power_ctrl_pkg::ADDR_RISE, 32'h10000);
    apb(1'b1, power_ctrl_pkg::ADDR_MASK, 32'h10000);
    apb(1'b1, power_ctrl_pkg::ADDR_AWU, 32'h2);
    enter(32'h101, 6'h02);
    wait_evt(16, 40);
    `CHK("awu_evt", 1'b1, seen)
    check_woken(16);
  endtask

  // Line 0 routed to pin 32: its own pin must no longer reach it
  task automatic t_route();
    apb(1'b1, power_ctrl_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, power_ctrl_pkg::ADDR_RISE, 32'h1);
    apb(1'b1, power_ctrl_pkg::ADDR_MASK, 32'h1);
    apb(1'b1, power_ctrl_pkg::ADDR_ROUTE, 32'h2);
    P.gpio_in[0] <= 1'b1;
    wait_evt(0, 4);
    `CHK("route_off", 1'b0, seen)
    P.gpio_in[32] <= 1'b1;
    wait_evt(0, 4);
    `CHK("route_on", 1'b1, seen)
  endtask

  // Each cause forces system reset and sets its sticky flag, read back while the cause stands
  task automatic t_causes();
    for (int i = 0; i < 4; i++) begin
      P.set_cause(i, 1'b1);
      repeat (2) @(posedge clock);
      @(negedge clock);
      `CHK("rst_on", 1'b0, sys_reset_b)
      @(posedge clock);
      apb(1'b0, power_ctrl_pkg::ADDR_STATUS, 32'h0);
      `CHK("flag", 2'h3, {rd[4+i], rd[8] | (i != 2)})
      P.set_cause(i, 1'b0);
      repeat (2) @(posedge clock);
      @(negedge clock);
      `CHK("rst_off", 1'b1, sys_reset_b)
      @(posedge clock);
      apb(1'b1, power_ctrl_pkg::ADDR_STATUS, 32'hf0);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0;
    n_fail = 0; tests_run = 0; cycles = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    `CHK("regon", 2'h3, {core_reg_on, sys_reset_b})
    `CHK("mult", 8'h12, {3'h0, mult_factor})
    @(posedge clock);
    rdchk("awu_rst", power_ctrl_pkg::ADDR_AWU, 32'hffff);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    t_sleep();
    t_stop();
    t_standby();
    t_autowake();
    t_route();
    t_causes();
    report_and_stop();
  end
`undef CHK
endmodule
`default_nettype wire
